// ### hw/rcrb_reg_bank.v
// Behaviour
// - registers decode at fixed offset plus configured base, 256-byte window.
// - pin input registers read live pin levels; writes ignored.
// - port A/B mode bits: 0 processor I/O, 1 address out; readable.
// - output registers set pin level, read back; logic-cell driven pins ignore.
// - direction bit 1 output, 0 input; readable.
// - drive type per pin push-pull/open-drain/slew, readable, default push-pull.
// - input logic cell registers read cell state; no writes.
// - driver-on registers read-only, 1 driver enabled, 0 high impedance.
// - two cell banks of eight; read outputs, write loads flip-flops.
// - mask bit 1 blocks processor read/write of that cell; readable.
// - main flash protection read-only, shows non-volatile setting.
// - secondary protection and secure bit read-only; secure bit follows nv_secure_in.
// - first two power registers fully read/write.
// - third power register read/write; bit 1 cleared only by reset.
// - page register read/write and drives page number out.
// - routing writes override non-volatile placement; reset restores it.
// - routing low five bits gate read, write, fetch strobes to memories.
// - routing bit 7 enables peripheral I/O on port A; reset clears it.
`timescale 1ns/100ps
`include "rcrb_map.vh"
`default_nettype none
module rcrb_reg_bank (
    // clock and reset
    input wire mclk_in,
    input wire sys_rst_in,
    // processor data bus
    input wire [15:0] bus_addr_in,
    input wire [7:0] bus_wdata_in,
    input wire bus_rd_in,
    input wire bus_wr_in,
    input wire bus_fetch_in,
    input wire [15:0] window_base_in,
    output reg [7:0] bus_rdata_out,
    // non-volatile configuration
    input wire [4:0] nv_route_in,
    input wire [7:0] nv_main_prot_in,
    input wire [6:0] nv_sec_prot_in,
    input wire nv_secure_in,
    // port pins and logic array
    input wire [31:0] pin_level_in,
    input wire [31:0] cell_drives_pin_in,
    input wire [15:0] cell_pin_value_in,
    input wire [23:0] input_cell_in,
    input wire [15:0] output_logic_cell_in,
    // port controls
    output reg [31:0] pin_out_out,
    output reg [31:0] pin_oe_out,
    output reg [31:0] drive_type_out,
    output reg [15:0] addr_out_sel_out,
    // logic cell load
    output reg [15:0] cell_load_data_out,
    output reg [15:0] cell_load_en_out,
    // memory control
    output reg [7:0] power_ctrl_first_out,
    output reg [7:0] power_ctrl_second_out,
    output reg [7:0] power_ctrl_third_out,
    output reg [7:0] page_out,
    output reg peripheral_io_enable_out,
    output reg main_flash_rd_out,
    output reg main_flash_wr_out,
    output reg main_flash_fetch_out,
    output reg sec_flash_rd_out,
    output reg sec_flash_wr_out,
    output reg sec_flash_fetch_out,
    output reg sram_fetch_out
);
    // ****************************************
    // decode
    // ****************************************
    wire [15:0] rel_w = bus_addr_in - window_base_in;
    wire hit_w = (bus_addr_in >= window_base_in) && (rel_w[15:8] == 8'h00);
    wire [7:0] off_w = rel_w[7:0];
    wire wr_w = hit_w & bus_wr_in;
    wire rd_w = hit_w & bus_rd_in;
    // ****************************************
    // registers
    // ****************************************
    reg [31:0] out_q;
    reg [31:0] dir_q;
    reg [31:0] drv_q;
    reg [15:0] sel_q;
    reg [15:0] mask_q;
    reg [7:0] pwr1_q;
    reg [7:0] pwr2_q;
    reg [7:0] pwr3_q;
    reg [7:0] page_q;
    reg [7:0] route_q;
    reg route_ld_q;
    // per-port offsets, index 0..3 = ports a..d
    function [7:0] out_off;
        input [1:0] p;
        case (p)
            2'd0: out_off = `RCRB_OFF_A_OUT;
            2'd1: out_off = `RCRB_OFF_B_OUT;
            2'd2: out_off = `RCRB_OFF_C_OUT;
            default: out_off = `RCRB_OFF_D_OUT;
        endcase
    endfunction
    function [7:0] dir_off;
        input [1:0] p;
        case (p)
            2'd0: dir_off = `RCRB_OFF_A_DIR;
            2'd1: dir_off = `RCRB_OFF_B_DIR;
            2'd2: dir_off = `RCRB_OFF_C_DIR;
            default: dir_off = `RCRB_OFF_D_DIR;
        endcase
    endfunction
    function [7:0] drv_off;
        input [1:0] p;
        case (p)
            2'd0: drv_off = `RCRB_OFF_A_DRV;
            2'd1: drv_off = `RCRB_OFF_B_DRV;
            2'd2: drv_off = `RCRB_OFF_C_DRV;
            default: drv_off = `RCRB_OFF_D_DRV;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : port_regs
            always @(posedge mclk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    out_q[g*8 +: 8] <= `RCRB_RST_BYTE;
                    dir_q[g*8 +: 8] <= `RCRB_RST_BYTE;
                    drv_q[g*8 +: 8] <= `RCRB_RST_DRV;
                end else begin
                    if (wr_w && off_w == out_off(g))
                        out_q[g*8 +: 8] <= bus_wdata_in;
                    if (wr_w && off_w == dir_off(g))
                        dir_q[g*8 +: 8] <= bus_wdata_in;
                    if (wr_w && off_w == drv_off(g))
                        drv_q[g*8 +: 8] <= bus_wdata_in;
                end
            end
        end
    endgenerate

    // strap value for routing is caught on the first clock after release
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sel_q <= 16'h0000;
            mask_q <= 16'h0000;
            pwr1_q <= `RCRB_RST_BYTE;
            pwr2_q <= `RCRB_RST_BYTE;
            pwr3_q <= `RCRB_RST_BYTE;
            page_q <= `RCRB_RST_BYTE;
            route_q <= `RCRB_RST_BYTE;
            route_ld_q <= 1'b1;
        end else begin
            route_ld_q <= 1'b0;
            if (route_ld_q)
                route_q <= {3'b000, nv_route_in};
            else if (wr_w && off_w == `RCRB_OFF_ROUTE)
                route_q <= {bus_wdata_in[7], 2'b00, bus_wdata_in[4:0]};
            if (wr_w && off_w == `RCRB_OFF_A_ADDR_SEL)
                sel_q[7:0] <= bus_wdata_in;
            if (wr_w && off_w == `RCRB_OFF_B_ADDR_SEL)
                sel_q[15:8] <= bus_wdata_in;
            if (wr_w && off_w == `RCRB_OFF_MASK_LO)
                mask_q[7:0] <= bus_wdata_in;
            if (wr_w && off_w == `RCRB_OFF_MASK_HI)
                mask_q[15:8] <= bus_wdata_in;
            if (wr_w && off_w == `RCRB_OFF_PWR1)
                pwr1_q <= bus_wdata_in;
            if (wr_w && off_w == `RCRB_OFF_PWR2)
                pwr2_q <= bus_wdata_in;
            if (wr_w && off_w == `RCRB_OFF_PWR3) begin
                pwr3_q <= bus_wdata_in;
                // sticky bit: a write may set it but never clear it
                pwr3_q[`RCRB_PWR3_STICKY_BIT] <= bus_wdata_in[`RCRB_PWR3_STICKY_BIT]
                    | pwr3_q[`RCRB_PWR3_STICKY_BIT];
            end
            if (wr_w && off_w == `RCRB_OFF_PAGE)
                page_q <= bus_wdata_in;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    wire [15:0] cell_vis_w = output_logic_cell_in & ~mask_q;
    reg [7:0] rd_d;
    always @* begin
        case (off_w)
            `RCRB_OFF_A_IN: rd_d = pin_level_in[7:0];
            `RCRB_OFF_B_IN: rd_d = pin_level_in[15:8];
            `RCRB_OFF_C_IN: rd_d = pin_level_in[23:16];
            `RCRB_OFF_D_IN: rd_d = pin_level_in[31:24];
            `RCRB_OFF_A_ADDR_SEL: rd_d = sel_q[7:0];
            `RCRB_OFF_B_ADDR_SEL: rd_d = sel_q[15:8];
            `RCRB_OFF_A_OUT: rd_d = out_q[7:0];
            `RCRB_OFF_B_OUT: rd_d = out_q[15:8];
            `RCRB_OFF_C_OUT: rd_d = out_q[23:16];
            `RCRB_OFF_D_OUT: rd_d = out_q[31:24];
            `RCRB_OFF_A_DIR: rd_d = dir_q[7:0];
            `RCRB_OFF_B_DIR: rd_d = dir_q[15:8];
            `RCRB_OFF_C_DIR: rd_d = dir_q[23:16];
            `RCRB_OFF_D_DIR: rd_d = dir_q[31:24];
            `RCRB_OFF_A_DRV: rd_d = drv_q[7:0];
            `RCRB_OFF_B_DRV: rd_d = drv_q[15:8];
            `RCRB_OFF_C_DRV: rd_d = drv_q[23:16];
            `RCRB_OFF_D_DRV: rd_d = drv_q[31:24];
            `RCRB_OFF_A_ICELL: rd_d = input_cell_in[7:0];
            `RCRB_OFF_B_ICELL: rd_d = input_cell_in[15:8];
            `RCRB_OFF_C_ICELL: rd_d = input_cell_in[23:16];
            `RCRB_OFF_A_DRV_ON: rd_d = pin_oe_out[7:0];
            `RCRB_OFF_B_DRV_ON: rd_d = pin_oe_out[15:8];
            `RCRB_OFF_C_DRV_ON: rd_d = pin_oe_out[23:16];
            `RCRB_OFF_D_DRV_ON: rd_d = pin_oe_out[31:24];
            `RCRB_OFF_CELL_LO: rd_d = cell_vis_w[7:0];
            `RCRB_OFF_CELL_HI: rd_d = cell_vis_w[15:8];
            `RCRB_OFF_MASK_LO: rd_d = mask_q[7:0];
            `RCRB_OFF_MASK_HI: rd_d = mask_q[15:8];
            `RCRB_OFF_PWR1: rd_d = pwr1_q;
            `RCRB_OFF_PWR2: rd_d = pwr2_q;
            `RCRB_OFF_MAIN_PROT: rd_d = nv_main_prot_in;
            `RCRB_OFF_SEC_PROT: rd_d = {nv_secure_in, nv_sec_prot_in};
            `RCRB_OFF_PWR3: rd_d = pwr3_q;
            `RCRB_OFF_PAGE: rd_d = page_q;
            `RCRB_OFF_ROUTE: rd_d = route_q;
            default: rd_d = 8'h00;
        endcase
    end

    // ****************************************
    // registered outputs
    // ****************************************
    // outputs lag the registers by one clock so every port is a flip-flop
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_rdata_out <= 8'h00;
            pin_out_out <= 32'h0000_0000;
            pin_oe_out <= 32'h0000_0000;
            drive_type_out <= 32'h0000_0000;
            addr_out_sel_out <= 16'h0000;
            cell_load_data_out <= 16'h0000;
            cell_load_en_out <= 16'h0000;
            power_ctrl_first_out <= 8'h00;
            power_ctrl_second_out <= 8'h00;
            power_ctrl_third_out <= 8'h00;
            page_out <= 8'h00;
            peripheral_io_enable_out <= 1'b0;
            main_flash_rd_out <= 1'b0;
            main_flash_wr_out <= 1'b0;
            main_flash_fetch_out <= 1'b0;
            sec_flash_rd_out <= 1'b0;
            sec_flash_wr_out <= 1'b0;
            sec_flash_fetch_out <= 1'b0;
            sram_fetch_out <= 1'b0;
        end else begin
            bus_rdata_out <= rd_w ? rd_d : 8'h00;
            // logic-cell driven pins 0-15 take the cell value, pins 16-31 drive 0; neither uses the register
            pin_out_out <= (out_q & ~cell_drives_pin_in)
                | ({16'h0000, cell_pin_value_in} & cell_drives_pin_in);
            pin_oe_out <= dir_q | cell_drives_pin_in;
            drive_type_out <= drv_q;
            addr_out_sel_out <= sel_q;
            cell_load_data_out <= {bus_wdata_in, bus_wdata_in};
            cell_load_en_out <= {
                {8{wr_w && off_w == `RCRB_OFF_CELL_HI}},
                {8{wr_w && off_w == `RCRB_OFF_CELL_LO}}} & ~mask_q;
            power_ctrl_first_out <= pwr1_q;
            power_ctrl_second_out <= pwr2_q;
            power_ctrl_third_out <= pwr3_q;
            page_out <= page_q;
            peripheral_io_enable_out <= route_q[`RCRB_ROUTE_PIO_BIT];
            main_flash_rd_out <= bus_rd_in & route_q[4];
            main_flash_wr_out <= bus_wr_in & route_q[4];
            sec_flash_rd_out <= bus_rd_in & route_q[3];
            sec_flash_wr_out <= bus_wr_in & route_q[3];
            main_flash_fetch_out <= bus_fetch_in & route_q[2];
            sec_flash_fetch_out <= bus_fetch_in & route_q[1];
            sram_fetch_out <= bus_fetch_in & route_q[0];
        end
    end
endmodule
`default_nettype wire

// ### pkg/rcrb_map.vh
`ifndef RCRB_MAP_VH
`define RCRB_MAP_VH
// ****************************************
// offsets within the 256-byte window
// ****************************************
`define RCRB_OFF_A_IN 8'h00
`define RCRB_OFF_B_IN 8'h01
`define RCRB_OFF_A_ADDR_SEL 8'h02
`define RCRB_OFF_B_ADDR_SEL 8'h03
`define RCRB_OFF_A_OUT 8'h04
`define RCRB_OFF_B_OUT 8'h05
`define RCRB_OFF_A_DIR 8'h06
`define RCRB_OFF_B_DIR 8'h07
`define RCRB_OFF_A_DRV 8'h08
`define RCRB_OFF_B_DRV 8'h09
`define RCRB_OFF_A_ICELL 8'h0a
`define RCRB_OFF_B_ICELL 8'h0b
`define RCRB_OFF_A_DRV_ON 8'h0c
`define RCRB_OFF_B_DRV_ON 8'h0d
`define RCRB_OFF_C_IN 8'h10
`define RCRB_OFF_D_IN 8'h11
`define RCRB_OFF_C_OUT 8'h12
`define RCRB_OFF_D_OUT 8'h13
`define RCRB_OFF_C_DIR 8'h14
`define RCRB_OFF_D_DIR 8'h15
`define RCRB_OFF_C_DRV 8'h16
`define RCRB_OFF_D_DRV 8'h17
`define RCRB_OFF_C_ICELL 8'h18
`define RCRB_OFF_C_DRV_ON 8'h1a
`define RCRB_OFF_D_DRV_ON 8'h1b
`define RCRB_OFF_CELL_LO 8'h20
`define RCRB_OFF_CELL_HI 8'h21
`define RCRB_OFF_MASK_LO 8'h22
`define RCRB_OFF_MASK_HI 8'h23
`define RCRB_OFF_PWR1 8'hb0
`define RCRB_OFF_PWR2 8'hb4
`define RCRB_OFF_MAIN_PROT 8'hc0
`define RCRB_OFF_SEC_PROT 8'hc2
`define RCRB_OFF_PWR3 8'hc7
`define RCRB_OFF_PAGE 8'he0
`define RCRB_OFF_ROUTE 8'he2
// ****************************************
// fields and reset values
// ****************************************
`define RCRB_PWR3_STICKY_BIT 1
`define RCRB_ROUTE_PIO_BIT 7
`define RCRB_ROUTE_MEM_MSB 4
`define RCRB_SEC_BIT 7
`define RCRB_RST_BYTE 8'h00
`define RCRB_RST_DRV 8'h00
`endif

// ### verif/rcrb_reg_bank_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rcrb_reg_bank_checker (
    // clock and bus
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_rd_in,
    input wire logic bus_wr_in,
    input wire logic [15:0] window_base_in,
    input wire logic [7:0] bus_rdata_out,
    // status and controls
    input wire logic [7:0] nv_main_prot_in,
    input wire logic [6:0] nv_sec_prot_in,
    input wire logic nv_secure_in,
    input wire logic [31:0] pin_level_in,
    input wire logic [15:0] cell_load_en_out,
    input wire logic [7:0] power_ctrl_third_out,
    input wire logic [7:0] page_out,
    input wire logic peripheral_io_enable_out
);
    // ****************************************
    // window offset, wraps high below the base
    // ****************************************
    wire logic [15:0] off = bus_addr_in - window_base_in;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    AST_OUTSIDE: assert property (
        bus_rd_in && off[15:8] != 8'h00 |=> bus_rdata_out == 8'h00)
        else $error("read outside the window returned data");
    AST_UNUSED: assert property (
        bus_rd_in && off >= 16'h0024 && off < 16'h00b0 |=> !(|bus_rdata_out))
        else $error("unassigned offset read not zero");
    AST_PIN_A: assert property (
        bus_rd_in && off == 16'h0000 |=> bus_rdata_out == $past(pin_level_in[7:0]))
        else $error("pin input read differs from pins");
    AST_MAIN_PROT: assert property (
        bus_rd_in && off == 16'h00c0 |=> bus_rdata_out == $past(nv_main_prot_in))
        else $error("main protection read differs");
    AST_SEC: assert property (
        bus_rd_in && off == 16'h00c2 |=>
        bus_rdata_out == {$past(nv_secure_in), $past(nv_sec_prot_in)})
        else $error("security read differs");
    AST_PWR3_HOLD: assert property (
        power_ctrl_third_out[1] |=> power_ctrl_third_out[1])
        else $error("sticky power bit cleared without reset");
    AST_PIO_RESET: assert property (
        $fell(sys_rst_in) |-> !peripheral_io_enable_out)
        else $error("peripheral io enable set after reset");
    AST_PIO_WRITE: assert property (
        bus_wr_in && off == 16'h00e2 |=> ##1
        peripheral_io_enable_out == $past(bus_wdata_in[7], 2))
        else $error("peripheral io enable not loaded");
    AST_PAGE: assert property (
        bus_wr_in && off == 16'h00e0 |=> ##1 page_out == $past(bus_wdata_in, 2))
        else $error("page output not loaded");
    AST_LOAD: assert property (
        |cell_load_en_out |-> $past(bus_wr_in) || $past(bus_wr_in, 2))
        else $error("cell load without a write");
endmodule
bind rcrb_reg_bank rcrb_reg_bank_checker u_chk (.*);
`default_nettype wire

// ### verif/rcrb_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcrb_cpu_model (
    // clock and read data
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    // bus requests
    output logic [15:0] addr_out,
    output logic [7:0] wdata_out,
    output logic rd_out,
    output logic wr_out,
    output logic fetch_out
);
    // ****************************************
    // byte bus cycles
    // ****************************************
    initial begin
        addr_out = 16'h0000;
        wdata_out = 8'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        fetch_out = 1'b0;
    end
    // callers aim writes at assigned offsets only
    task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        // released lines show the inverse so stale values never look valid
        addr_out = ~a;
        wdata_out = ~d;
    endtask
    task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        d = rdata_in;
        rd_out = 1'b0;
        addr_out = ~a;
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [15:0] B = 16'h7f00;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [15:0] addr, load_en;
    logic [7:0] wdata, rdata, page, pwr3, got;
    logic rd, wr, fetch, pio, mrd;
    logic [15:0] base = B;
    logic [15:0] cells = 16'hbeef;
    logic secure = 1'b1;
    logic [4:0] nv_route = 5'h0c;
    logic [31:0] pins = 32'ha5c33c5a;
    logic [31:0] cell_drv = 32'h0;
    logic [31:0] pin_out, pin_oe, drv;
    int err_count = 0;
    int n_checks = 0;
    logic [7:0] rw_offs [19] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23,
        8'hb0, 8'hb4, 8'he0};
    logic [7:0] ro_offs [7] = '{8'h00, 8'h11, 8'h0a, 8'h0b, 8'h18, 8'hc0, 8'hc2};
    logic [7:0] ro_exp [7] = '{8'h5a, 8'ha5, 8'h56, 8'h34, 8'h12, 8'h6b, 8'h95};
    always #25 mclk_in = ~mclk_in;
    rcrb_cpu_model u_cpu (.clk_in(mclk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .rd_out(rd), .wr_out(wr), .fetch_out(fetch));
    rcrb_reg_bank u_rcrb_reg_bank (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_rd_in(rd),
        .bus_wr_in(wr), .bus_fetch_in(fetch), .window_base_in(base),
        .bus_rdata_out(rdata), .nv_route_in(nv_route),
        .nv_main_prot_in(8'h6b), .nv_sec_prot_in(7'h15), .nv_secure_in(secure),
        .pin_level_in(pins), .cell_drives_pin_in(cell_drv),
        .cell_pin_value_in(16'hffff), .input_cell_in(24'h123456),
        .output_logic_cell_in(cells), .pin_out_out(pin_out),
        .pin_oe_out(pin_oe), .drive_type_out(drv), .addr_out_sel_out(),
        .cell_load_data_out(), .cell_load_en_out(load_en),
        .power_ctrl_first_out(), .power_ctrl_second_out(),
        .power_ctrl_third_out(pwr3), .page_out(page),
        .peripheral_io_enable_out(pio), .main_flash_rd_out(mrd),
        .main_flash_wr_out(), .main_flash_fetch_out(), .sec_flash_rd_out(),
        .sec_flash_wr_out(), .sec_flash_fetch_out(), .sram_fetch_out());
    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] o, input logic [7:0] d);
        u_cpu.write_reg(B + {8'h00, o}, d);
    endtask
    task automatic rchk(input logic [7:0] o, input logic [7:0] e);
        u_cpu.read_reg(B + {8'h00, o}, got);
        chk(got, e);
    endtask
    task automatic do_reset;
        sys_rst_in = 1'b1;
        repeat (12) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        $display("wrong value at %0t: run timed out", $time);
        complete_run;
    end
    initial begin
        do_reset;
        rchk(8'he2, 8'h0c);
        chk({7'h0, mrd}, 8'h00);
        rchk(8'h08, 8'h00);
        chk({7'h0, pio}, 8'h00);
        $display("test reset values done");
        foreach (rw_offs[i]) wr_reg(rw_offs[i], rw_offs[i] ^ 8'ha5);
        foreach (rw_offs[i]) rchk(rw_offs[i], rw_offs[i] ^ 8'ha5);
        chk(pin_out[7:0], 8'ha1);
        chk(pin_oe[15:8], 8'ha2);
        chk(drv[31:24], 8'hb2);
        chk(page, 8'h45);
        rchk(8'h0c, 8'ha3);
        cell_drv = 32'h0000000f;
        repeat (3) @(posedge mclk_in);
        #1;
        chk(pin_out[7:0], 8'haf);
        rchk(8'h04, 8'ha1);
        rchk(8'h0c, 8'haf);
        $display("test port registers done");
        wr_reg(8'h22, 8'h00);
        wr_reg(8'h20, 8'h3c);
        chk(load_en[7:0], 8'hff);
        rchk(8'h20, 8'hef);
        wr_reg(8'h22, 8'hf0);
        rchk(8'h20, 8'h0f);
        wr_reg(8'h23, 8'hff);
        rchk(8'h21, 8'h00);
        $display("test logic cells done");
        foreach (ro_offs[i]) begin
            wr_reg(ro_offs[i], ~ro_exp[i]);
            rchk(ro_offs[i], ro_exp[i]);
        end
        secure = 1'b0;
        rchk(8'hc2, 8'h15);
        rchk(8'h30, 8'h00);
        u_cpu.read_reg(B - 16'h0001, got);
        chk(got, 8'h00);
        $display("test read-only and unassigned done");
        wr_reg(8'hc7, 8'h02);
        wr_reg(8'hc7, 8'h00);
        rchk(8'hc7, 8'h02);
        chk(pwr3, 8'h02);
        wr_reg(8'he2, 8'hf3);
        rchk(8'he2, 8'h93);
        chk({7'h0, mrd}, 8'h01);
        chk({7'h0, pio}, 8'h01);
        nv_route = 5'h11;
        do_reset;
        rchk(8'he2, 8'h11);
        rchk(8'hc7, 8'h00);
        chk({7'h0, pio}, 8'h00);
        $display("test power and routing done");
        complete_run;
    end
endmodule
`default_nettype wire
